// ### shared/gpio_bank_pkg.sv
`default_nettype none

package gpio_bank_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT9_DIR      = 8'hd0;
  localparam logic [7:0] IDX_PORTA_DIR      = 8'hd1;
  localparam logic [7:0] IDX_PORT9_DATA     = 8'hd2;
  localparam logic [7:0] IDX_PORTA_DATA     = 8'hd3;
  localparam logic [7:0] IDX_PORTB_DIR      = 8'hd4;
  localparam logic [7:0] IDX_PORTB_DATA     = 8'hd6;
  localparam logic [7:0] IDX_PORT2_PULLUP   = 8'hd8;
  localparam logic [7:0] IDX_PORT5_PULLUP   = 8'hdb;
  localparam logic [7:0] IDX_PORT2_DIR      = 8'hdc;
  localparam logic [7:0] IDX_PORT5_DIR      = 8'hdd;

  // reset values and fixed bits
  localparam logic [7:0] RST_ZERO           = 8'h00;
  localparam logic [7:0] PORT9_RSVD_ONES    = 8'hc0;
  localparam logic [7:0] PORT5_RSVD_ONES    = 8'hf0;
  localparam logic [7:0] PORTB_DIR_MASK     = 8'hbf;
  localparam logic [7:0] WO_READ_VALUE      = 8'h00;

  // pin counts and synchroniser depth
  localparam int PORT9_PINS = 6;
  localparam int PORT5_PINS = 4;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic [7:0] port2;
    logic [3:0] port5;
  } pullup_s;

endpackage : gpio_bank_pkg

`default_nettype wire

// ### src/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-flop synchroniser; the first stage feeds only the second
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // asynchronous pins and their synchronised copy
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : pin_sync

`default_nettype wire

// ### src/gpio_bank.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module gpio_bank #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // port 9 pins
  input  wire logic [5:0]           port9_in,
  output logic      [5:0]           port9_out,
  output logic      [5:0]           port9_oe,
  // port a pins
  input  wire logic [7:0]           porta_in,
  output logic      [7:0]           porta_out,
  output logic      [7:0]           porta_oe,
  // port b pins
  input  wire logic [7:0]           portb_in,
  output logic      [7:0]           portb_out,
  output logic      [7:0]           portb_oe,
  // port 2 and port 5 control
  output logic      [7:0]           port2_direction,
  output logic      [3:0]           port5_direction,
  output gpio_bank_pkg::pullup_s    pullup_on
);

  if (ADDR_W < 10) begin : g_chk
    $error("gpio_bank: ADDR_W must be at least 10");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction : hit

  function automatic logic [7:0] pin_view(input logic [7:0] dir, input logic [7:0] lat,
                                          input logic [7:0] pin);
    return (dir & lat) | (~dir & pin);
  endfunction : pin_view

  // registers
  logic [5:0] p9_dir_q;
  logic [7:0] pa_dir_q;
  logic [7:0] pb_dir_q;
  logic [5:0] p9_dat_q;
  logic [7:0] pa_dat_q;
  logic [7:0] pb_dat_q;
  logic [7:0] p2_pu_q;
  logic [3:0] p5_pu_q;
  logic [7:0] p2_dir_q;
  logic [3:0] p5_dir_q;
  logic [31:0] prdata_q;

  // synchronised pins
  logic [21:0] sync_all;
  logic [5:0]  sync_9;
  logic [7:0]  sync_a;
  logic [7:0]  sync_b;

  pin_sync #(
    .WIDTH    (22)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({port9_in, porta_in, portb_in}),
    .sync_out (sync_all)
  );

  assign sync_9 = sync_all[21:16];
  assign sync_a = sync_all[15:8];
  assign sync_b = sync_all[7:0];

  // address decode
  wire sel_p9_dir  = hit(paddr, gpio_bank_pkg::IDX_PORT9_DIR);
  wire sel_pa_dir  = hit(paddr, gpio_bank_pkg::IDX_PORTA_DIR);
  wire sel_p9_dat  = hit(paddr, gpio_bank_pkg::IDX_PORT9_DATA);
  wire sel_pa_dat  = hit(paddr, gpio_bank_pkg::IDX_PORTA_DATA);
  wire sel_pb_dir  = hit(paddr, gpio_bank_pkg::IDX_PORTB_DIR);
  wire sel_pb_dat  = hit(paddr, gpio_bank_pkg::IDX_PORTB_DATA);
  wire sel_p2_pu   = hit(paddr, gpio_bank_pkg::IDX_PORT2_PULLUP);
  wire sel_p5_pu   = hit(paddr, gpio_bank_pkg::IDX_PORT5_PULLUP);
  wire sel_p2_dir  = hit(paddr, gpio_bank_pkg::IDX_PORT2_DIR);
  wire sel_p5_dir  = hit(paddr, gpio_bank_pkg::IDX_PORT5_DIR);
  wire mapped      = sel_p9_dir | sel_pa_dir | sel_p9_dat | sel_pa_dat | sel_pb_dir
                   | sel_pb_dat | sel_p2_pu | sel_p5_pu | sel_p2_dir | sel_p5_dir;

  wire setup_ph    = psel & ~penable;
  wire access_ph   = psel & penable;
  // only byte lane 0 carries register data
  wire wr_en       = access_ph & pwrite & pstrb[0] & mapped;
  wire [7:0] wbyte = pwdata[7:0];

  // pin view of each data register
  wire [7:0] view_9 = pin_view({2'b00, p9_dir_q}, {2'b00, p9_dat_q}, {2'b00, sync_9});
  wire [7:0] view_a = pin_view(pa_dir_q, pa_dat_q, sync_a);
  wire [7:0] view_b = pin_view(pb_dir_q, pb_dat_q, sync_b);

  wire [7:0] rd_byte =
      sel_p9_dat ? (gpio_bank_pkg::PORT9_RSVD_ONES | view_9) :
      sel_pa_dat ? view_a :
      sel_pb_dat ? view_b :
      sel_p2_pu  ? p2_pu_q :
      sel_p5_pu  ? (gpio_bank_pkg::PORT5_RSVD_ONES | {4'h0, p5_pu_q}) :
                   gpio_bank_pkg::WO_READ_VALUE;

  // direction and pull-up registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p9_dir_q <= '0;
      pa_dir_q <= gpio_bank_pkg::RST_ZERO;
      pb_dir_q <= gpio_bank_pkg::RST_ZERO;
      p2_dir_q <= gpio_bank_pkg::RST_ZERO;
      p5_dir_q <= '0;
      p2_pu_q  <= gpio_bank_pkg::RST_ZERO;
      p5_pu_q  <= '0;
    end else if (wr_en) begin
      if (sel_p9_dir) p9_dir_q <= wbyte[5:0];
      if (sel_pa_dir) pa_dir_q <= wbyte;
      if (sel_pb_dir) pb_dir_q <= wbyte & gpio_bank_pkg::PORTB_DIR_MASK;
      if (sel_p2_dir) p2_dir_q <= wbyte;
      if (sel_p5_dir) p5_dir_q <= wbyte[3:0];
      if (sel_p2_pu)  p2_pu_q  <= wbyte;
      if (sel_p5_pu)  p5_pu_q  <= wbyte[3:0];
    end
  end

  // data latches keep their value while the pin is an input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p9_dat_q <= '0;
      pa_dat_q <= gpio_bank_pkg::RST_ZERO;
      pb_dat_q <= gpio_bank_pkg::RST_ZERO;
    end else if (wr_en) begin
      if (sel_p9_dat) p9_dat_q <= wbyte[5:0];
      if (sel_pa_dat) pa_dat_q <= wbyte;
      if (sel_pb_dat) pb_dat_q <= wbyte;
    end
  end

  // read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
  end

  assign prdata    = prdata_q;
  assign pready    = 1'b1;
  assign pslverr   = access_ph & ~mapped;

  assign port9_out = p9_dat_q;
  assign port9_oe  = p9_dir_q;
  assign porta_out = pa_dat_q;
  assign porta_oe  = pa_dir_q;
  assign portb_out = pb_dat_q;
  assign portb_oe  = pb_dir_q;

  assign port2_direction = p2_dir_q;
  assign port5_direction = p5_dir_q;
  // pull-ups act only on pins set as inputs
  assign pullup_on.port2 = p2_pu_q & ~p2_dir_q;
  assign pullup_on.port5 = p5_pu_q & ~p5_dir_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_porta_dir_drive: assert property (
    (wr_en && sel_pa_dir) |=> (porta_oe == $past(pwdata[7:0])))
    else $error("port A output enable does not follow direction write");

  a_portb_dir_mask: assert property (
    (wr_en && sel_pb_dir) |=> (portb_oe == ($past(pwdata[7:0]) & 8'hbf)) && !portb_oe[6])
    else $error("port B direction write not applied with bit 6 held low");

  a_portb_data_write: assert property (
    (wr_en && sel_pb_dat) |=> (portb_out == $past(pwdata[7:0])))
    else $error("port B data write not latched");

  a_port2_pullup_gate: assert property (
    ((pullup_on.port2 & port2_direction) == 8'h00)
      && ((p2_dir_q != 8'h00) || (pullup_on.port2 == p2_pu_q)))
    else $error("port 2 pull-up active on an output or missing on an input");

  a_port5_pullup_gate: assert property (
    (wr_en && sel_p5_pu && p5_dir_q == 4'h0) |=> (pullup_on.port5 == $past(pwdata[3:0])))
    else $error("port 5 pull-up not on for an input pin after write");

  a_porta_read_view: assert property (
    (setup_ph && !pwrite && sel_pa_dat) |=>
      (prdata == {24'h00_0000, ($past(pa_dir_q) & $past(pa_dat_q))
                 | (~$past(pa_dir_q) & $past(sync_a))}))
    else $error("port A read does not mix latch and pin by direction");

  a_unmapped_hold: assert property (
    (access_ph && !mapped) |-> pslverr ##1 ($stable(pa_dat_q) && $stable(pb_dat_q)))
    else $error("unmapped access changed state or gave no error");

endmodule : gpio_bank

`default_nettype wire

// ### dv/pin_board.sv
`timescale 1ns/10ps
`default_nettype none

// board side of one port: a driven pin follows the latch, an undriven one the board level
module pin_board #(
  parameter int W = 8
) (
  // device side
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  // board level and resolved pin
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] pin
);
  assign pin = (oe & out) | (~oe & ext);
endmodule : pin_board

`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [11:0]            paddr = '0;
  logic [31:0]            pwdata = '0;
  logic [3:0]             pstrb = '0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [5:0]             p9_in, p9_out, p9_oe;
  logic [7:0]             pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
  logic [7:0]             p2_dir;
  logic [3:0]             p5_dir;
  gpio_bank_pkg::pullup_s pullup_on;
  logic [5:0]             p9_ext = 6'h15;
  logic [7:0]             pa_ext = 8'ha5;
  logic [7:0]             pb_ext = 8'h4c;
  int                     failures = 0;
  int                     checked = 0;
  int                     cyc = 0;

  always #5 pclk = ~pclk;

  gpio_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port9_in(p9_in), .port9_out(p9_out),
    .port9_oe(p9_oe), .porta_in(pa_in), .porta_out(pa_out), .porta_oe(pa_oe),
    .portb_in(pb_in), .portb_out(pb_out), .portb_oe(pb_oe), .port2_direction(p2_dir),
    .port5_direction(p5_dir), .pullup_on(pullup_on));
  pin_board #(.W(6)) i_b9 (.out(p9_out), .oe(p9_oe), .ext(p9_ext), .pin(p9_in));
  pin_board i_ba (.out(pa_out), .oe(pa_oe), .ext(pa_ext), .pin(pa_in));
  pin_board i_bb (.out(pb_out), .oe(pb_oe), .ext(pb_ext), .pin(pb_in));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one apb transfer; answer taken at the edge where pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      input logic [3:0] st, output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] st = 4'hf);
    logic [31:0] rd;
    logic        er;
    xfer(1'b1, idx, wd, st, rd, er);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp,
                      input logic eerr = 1'b0);
    logic [31:0] rd;
    logic        er;
    xfer(1'b0, idx, 8'h00, 4'h0, rd, er);
    check(nm, rd, {24'h00_0000, exp});
    check({nm, "_err"}, {31'h0000_0000, er}, {31'h0000_0000, eerr});
  endtask : rchk

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // both synchroniser stages must hold real pin levels before the first read
    repeat (2) @(posedge pclk);
    check("pb_out_rst", 32'(pb_out), 32'h0000_0000);
    check("pb_oe_rst", 32'(pb_oe), 32'h0000_0000);
    check("pullup_rst", 32'(pullup_on), 32'h0000_0000);
    check("pready_rst", 32'(pready), 32'h0000_0001);
    rchk("p9_rst", gpio_bank_pkg::IDX_PORT9_DATA, 8'hd5);
    rchk("pa_rst", gpio_bank_pkg::IDX_PORTA_DATA, 8'ha5);
    rchk("p5_rst", gpio_bank_pkg::IDX_PORT5_PULLUP, 8'hf0);
    rchk("pbdir_wo", gpio_bank_pkg::IDX_PORTB_DIR, 8'h00);
    rchk("unmapped", 8'hff, 8'h00, 1'b1);
    wr(gpio_bank_pkg::IDX_PORTA_DIR, 8'h0f);
    wr(gpio_bank_pkg::IDX_PORTA_DATA, 8'h3c);
    check("pa_oe", 32'(pa_oe), 32'h0000_000f);
    check("pa_out", 32'(pa_out), 32'h0000_003c);
    rchk("pa_mix", gpio_bank_pkg::IDX_PORTA_DATA, 8'hac);
    wr(gpio_bank_pkg::IDX_PORTB_DIR, 8'hff);
    wr(gpio_bank_pkg::IDX_PORTB_DATA, 8'ha3);
    check("pb_oe", 32'(pb_oe), 32'h0000_00bf);
    check("pb_out", 32'(pb_out), 32'h0000_00a3);
    rchk("pb_mix", gpio_bank_pkg::IDX_PORTB_DATA, 8'he3);
    // a write without its byte strobe must leave the latch alone
    wr(gpio_bank_pkg::IDX_PORTB_DATA, 8'h00, 4'h0);
    check("pb_nostrb", 32'(pb_out), 32'h0000_00a3);
    wr(8'hff, 8'h00);
    check("pb_unmapped", 32'(pb_out), 32'h0000_00a3);
    wr(gpio_bank_pkg::IDX_PORT9_DIR, 8'h3f);
    wr(gpio_bank_pkg::IDX_PORT9_DATA, 8'h2a);
    check("p9_oe", 32'(p9_oe), 32'h0000_003f);
    check("p9_out", 32'(p9_out), 32'h0000_002a);
    rchk("p9_out", gpio_bank_pkg::IDX_PORT9_DATA, 8'hea);
    wr(gpio_bank_pkg::IDX_PORT2_PULLUP, 8'hff);
    wr(gpio_bank_pkg::IDX_PORT2_DIR, 8'h0f);
    check("p2_dir", 32'(p2_dir), 32'h0000_000f);
    check("p2_pull", 32'(pullup_on.port2), 32'h0000_00f0);
    rchk("p2_rd", gpio_bank_pkg::IDX_PORT2_PULLUP, 8'hff);
    wr(gpio_bank_pkg::IDX_PORT5_PULLUP, 8'h5f);
    rchk("p5_rd", gpio_bank_pkg::IDX_PORT5_PULLUP, 8'hff);
    wr(gpio_bank_pkg::IDX_PORT5_DIR, 8'h03);
    check("p5_dir", 32'(p5_dir), 32'h0000_0003);
    check("p5_pull", 32'(pullup_on.port5), 32'h0000_000c);
    wr(gpio_bank_pkg::IDX_PORT5_PULLUP, 8'h0a);
    check("p5_pull2", 32'(pullup_on.port5), 32'h0000_0008);
    // a mid-run reset must return port B to all inputs and zero data
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("pb_out_rst2", 32'(pb_out), 32'h0000_0000);
    check("pb_oe_rst2", 32'(pb_oe), 32'h0000_0000);
    check("pullup_rst2", 32'(pullup_on), 32'h0000_0000);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
